// [cac_control_mode.sv]
// counter array run control, flags, timebase select and watchdog mode bits
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - set overflow flag on FFFF to 0000 wrap
// - overflow flag requests interrupt when enabled
// - run bit starts and stops the counter
// - control bits five to three read zero
// - module match events set flags zero to two
// - idle suspend halts array during cpu idle
// - watchdog enable resets to one, claims module2
// - lock blocks clearing watchdog enable until reset
// - three-bit select chooses counter timebase
// - count falling edges of external input
// - external clock divided by eight, then synchronised
// - watchdog enabled freezes other mode bits
// - mode bit four reads zero
// - writing 1 to module2 flag while watchdog enabled forces watchdog reset
// - watchdog forces counter on; run reads software
module cac_control_mode (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire cac_pkg::cac_sfr_req_t sfr,
  output logic [7:0]                 sfr_rdata,
  input  wire cac_pkg::cac_events_t  ev,
  input  wire logic [2:0]            module_irq_enable,
  output logic                       counter_array_irq,
  output logic                       watchdog_reset,
  output logic [15:0]                array_count,
  output logic                       count_tick,
  output logic                       watchdog_enable
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  control;
  logic [7:0]  next_control;
  logic [7:0]  mode;
  logic [7:0]  next_mode;
  logic [15:0] next_array_count;
  logic [3:0]  prescale;
  logic [3:0]  next_prescale;
  logic [2:0]  ext_div;
  logic [2:0]  next_ext_div;
  logic        ext_div_msb_q;
  logic        ext_sync1;
  logic        ext_sync2;
  logic        ext_sync3;
  logic        eci_q;
  logic        next_watchdog_reset;
  logic        running;
  logic        active;
  logic        tick;
  logic        ctl_wr;
  logic        md_wr;
  logic [2:0]  sel;

  assign ctl_wr = sfr.wr && (sfr.addr == cac_pkg::ADDR_CONTROL);
  assign md_wr  = sfr.wr && (sfr.addr == cac_pkg::ADDR_MODE);
  assign sel    = mode[cac_pkg::MD_SEL_LO +: 3];
  assign watchdog_enable = mode[cac_pkg::MD_WDEN];

  // counting runs while run bit or watchdog enable is set; idle suspend halts it
  assign running = control[cac_pkg::CTL_RUN] || watchdog_enable;
  assign active  = !(mode[cac_pkg::MD_IDLE] && ev.cpu_idle);

  ////////////////////////////////////////////////////////////////////////
  // external clock divide: own domain edge is sampled as a synchronous
  // input, so the divider runs on sampled edges; its msb is then synced
  logic ext_clk_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_clk_q <= 1'b0;
      eci_q     <= 1'b0;
    end else if (clk_en) begin
      ext_clk_q <= ev.external_clock;
      eci_q     <= ev.external_count_input;
    end
  end

  always_comb begin
    next_ext_div = ext_div;
    if (ev.external_clock && !ext_clk_q) begin
      next_ext_div = ext_div + 3'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_div       <= 3'h0;
      ext_div_msb_q <= 1'b0;
      ext_sync1     <= 1'b0;
      ext_sync2     <= 1'b0;
      ext_sync3     <= 1'b0;
    end else if (clk_en) begin
      ext_div       <= next_ext_div;
      ext_div_msb_q <= ext_div[2];
      ext_sync1     <= ext_div_msb_q;
      ext_sync2     <= ext_sync1;
      ext_sync3     <= ext_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase select
  always_comb begin
    next_prescale = prescale;
    tick = 1'b0;
    case (sel)
      cac_pkg::TB_DIV12: begin
        tick = (prescale >= cac_pkg::DIV12_LAST);
        next_prescale = tick ? 4'h0 : prescale + 4'h1;
      end
      cac_pkg::TB_DIV4: begin
        tick = (prescale >= cac_pkg::DIV4_LAST);
        next_prescale = tick ? 4'h0 : prescale + 4'h1;
      end
      cac_pkg::TB_T0OVF:   tick = ev.timer0_overflow;
      cac_pkg::TB_ECI:     tick = eci_q && !ev.external_count_input;
      cac_pkg::TB_SYS:     tick = 1'b1;
      cac_pkg::TB_EXTDIV8: tick = ext_sync2 && !ext_sync3;
      default:             tick = 1'b0;
    endcase
    if (!active) begin
      next_prescale = prescale;
      tick = 1'b0;
    end
  end
  assign count_tick = tick && running;

  ////////////////////////////////////////////////////////////////////////
  // counter and control register
  always_comb begin
    next_array_count = array_count;
    next_control = control;
    if (count_tick) begin
      next_array_count = array_count + 16'h0001;
    end
    if (ctl_wr) begin
      next_control = sfr.wdata & cac_pkg::CONTROL_WMASK;
    end
    // hardware sets win over a software clear in the same cycle
    if (count_tick && (array_count == 16'hFFFF)) begin
      next_control[cac_pkg::CTL_OVF] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (ev.match_event[i]) begin
        next_control[i] = 1'b1;
      end
    end
  end

  // watchdog reset: software writes 1 to module2 flag while enabled
  always_comb begin
    next_watchdog_reset = ctl_wr && sfr.wdata[cac_pkg::CTL_M2]
                          && watchdog_enable;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode register
  always_comb begin
    next_mode = mode;
    if (md_wr) begin
      if (watchdog_enable) begin
        // only enable/lock may change; lock keeps enable set
        next_mode[cac_pkg::MD_WDEN] = sfr.wdata[cac_pkg::MD_WDEN]
                                      || mode[cac_pkg::MD_LOCK];
        next_mode[cac_pkg::MD_LOCK] = sfr.wdata[cac_pkg::MD_LOCK]
                                      || mode[cac_pkg::MD_LOCK];
      end else begin
        next_mode = sfr.wdata & cac_pkg::MODE_WMASK;
        // setting lock also enables the watchdog
        if (sfr.wdata[cac_pkg::MD_LOCK]) begin
          next_mode[cac_pkg::MD_WDEN] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control        <= cac_pkg::CONTROL_RESET;
      mode           <= cac_pkg::MODE_RESET;
      array_count    <= 16'h0000;
      prescale       <= 4'h0;
      watchdog_reset <= 1'b0;
    end else if (clk_en) begin
      control        <= next_control;
      mode           <= next_mode;
      array_count    <= next_array_count;
      prescale       <= next_prescale;
      watchdog_reset <= next_watchdog_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request and read data
  assign counter_array_irq =
      (control[cac_pkg::CTL_OVF] && mode[cac_pkg::MD_IRQ])
      || |(control[2:0] & module_irq_enable);

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr.addr == cac_pkg::ADDR_CONTROL) begin
      sfr_rdata = control & cac_pkg::CONTROL_WMASK;
    end else if (sfr.addr == cac_pkg::ADDR_MODE) begin
      sfr_rdata = mode & cac_pkg::MODE_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_ovf_set;
    @(posedge clock) disable iff (rst)
    clk_en && count_tick && array_count == 16'hFFFF
      |=> control[cac_pkg::CTL_OVF] && array_count == 16'h0000;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_irq;
    @(posedge clock) disable iff (rst)
    control[cac_pkg::CTL_OVF] && mode[cac_pkg::MD_IRQ] |-> counter_array_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing interrupt");

  property p_flag_sticky;
    @(posedge clock) disable iff (rst)
    clk_en && control[cac_pkg::CTL_OVF] && !ctl_wr
      |=> control[cac_pkg::CTL_OVF];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_stopped;
    @(posedge clock) disable iff (rst)
    !control[cac_pkg::CTL_RUN] && !watchdog_enable |-> !count_tick;
  endproperty
  a_stopped: assert property (p_stopped) else $error("counted while off");

  property p_idle;
    @(posedge clock) disable iff (rst)
    mode[cac_pkg::MD_IDLE] && ev.cpu_idle |-> !count_tick;
  endproperty
  a_idle: assert property (p_idle) else $error("counted in idle");

  property p_lock;
    @(posedge clock) disable iff (rst)
    clk_en && mode[cac_pkg::MD_LOCK] |=> watchdog_enable;
  endproperty
  a_lock: assert property (p_lock) else $error("locked enable cleared");

  property p_frozen;
    @(posedge clock) disable iff (rst)
    clk_en && watchdog_enable |=> sel == $past(sel);
  endproperty
  a_frozen: assert property (p_frozen) else $error("select changed");

  property p_wdreset;
    @(posedge clock) disable iff (rst)
    clk_en && ctl_wr && sfr.wdata[2] && watchdog_enable |=> watchdog_reset;
  endproperty
  a_wdreset: assert property (p_wdreset) else $error("no wd reset");

  property p_sys_tick;
    @(posedge clock) disable iff (rst)
    sel == 3'h4 && active && running |-> count_tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("no sys tick");

  c_ovf:  cover property (@(posedge clock) control[cac_pkg::CTL_OVF]);
  c_wdr:  cover property (@(posedge clock) watchdog_reset);
  c_lock: cover property (@(posedge clock) mode[cac_pkg::MD_LOCK]);
endmodule
`default_nettype wire

// [cac_cpu_model.sv]
// processor core model issuing special function register cycles
`timescale 1ns/1ps
`default_nettype none
module cac_cpu_model (
  input  wire logic                  clock,
  input  wire logic [7:0]            rdata,
  output var  cac_pkg::cac_sfr_req_t sfr
);
  initial sfr = '0;
  ////////////////////////////////////////////////////////////////////////
  // flags only drop when software writes zero to them
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    #1;
    sfr.wr    = 1'b1;
    sfr.addr  = a;
    sfr.wdata = w;
    @(posedge clock);
    #1;
    sfr.wr    = 1'b0;
    sfr.wdata = ~w;
  endtask
  // read data taken at the edge that closes the read cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    sfr.rd   = 1'b1;
    sfr.addr = a;
    @(posedge clock);
    d = rdata;
    #1;
    sfr.rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// [cac_pkg.sv]
// package: register map, field positions and timing for the counter array
package cac_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'hD8;
  localparam logic [7:0] ADDR_MODE     = 8'hD9;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h40;
  // control fields
  localparam int CTL_OVF  = 7;
  localparam int CTL_RUN  = 6;
  localparam int CTL_M2   = 2;
  // mode fields
  localparam int MD_IDLE  = 7;
  localparam int MD_WDEN  = 6;
  localparam int MD_LOCK  = 5;
  localparam int MD_SEL_LO = 1;
  localparam int MD_IRQ   = 0;
  localparam logic [7:0] CONTROL_WMASK = 8'hC7;
  localparam logic [7:0] MODE_WMASK    = 8'hEF;
  // timebase
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0, TB_DIV4 = 3'h1, TB_T0OVF = 3'h2,
    TB_ECI = 3'h3, TB_SYS = 3'h4, TB_EXTDIV8 = 3'h5
  } cac_timebase_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cac_sfr_req_t;
  typedef struct packed {
    logic [2:0] match_event;
    logic       timer0_overflow;
    logic       external_count_input;
    logic       external_clock;
    logic       cpu_idle;
  } cac_events_t;
endpackage

// [tb_top.sv]
// testbench for counter array control and mode logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clock;
  logic                  rst;
  logic                  clk_en;
  cac_pkg::cac_sfr_req_t sfr;
  logic [7:0]            rdata;
  cac_pkg::cac_events_t  ev;
  logic [2:0]            irq_en;
  logic                  irq;
  logic                  wd_rst;
  logic [15:0]           count;
  logic                  tick;
  logic                  wd_en;
  logic [7:0]            d;
  logic [15:0]           c;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    seed = 32'he16b0440;
  int                    cyc = 0;
  int                    ctl;
  int                    md;
  int                    t;
  int                    gap[6] = '{12, 4, 5, 8, 1, 32};
  cac_control_mode DUT (.clock(clock), .rst(rst), .clk_en(clk_en),
    .sfr(sfr), .sfr_rdata(rdata), .ev(ev), .module_irq_enable(irq_en),
    .counter_array_irq(irq), .watchdog_reset(wd_rst),
    .array_count(count), .count_tick(tick), .watchdog_enable(wd_en));
  cac_cpu_model cpu (.clock(clock), .rdata(rdata), .sfr(sfr));
  ////////////////////////////////////////////////////////////////////////
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    #1;
    ev.external_count_input = cyc[2];
    ev.external_clock = cyc[1];
    ev.timer0_overflow = (cyc % 5 == 0);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(bit m, int exp);
    cpu.rd(m ? cac_pkg::ADDR_MODE : cac_pkg::ADDR_CONTROL, d);
    chk("sfr_rdata", exp[7:0], {8'h00, d});
  endtask
  // model: frozen fields while watchdog on, lock sticks and forces enable
  task automatic wr(bit m, int w);
    int n;
    if (!m) ctl = w & 8'hC7;
    else begin
      n = md[6] ? (md & 8'h9F) | (w & 8'h60) : w & 8'hEF;
      n = n | (md & 8'h20);
      md = (n & 8'h20) ? n | 8'h40 : n;
    end
    cpu.wr(m ? cac_pkg::ADDR_MODE : cac_pkg::ADDR_CONTROL, w[7:0]);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    ctl = 0;
    md = 8'h40;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(90000 * 50);
    n_errors++;
    end_of_test();
  end
  initial begin
    clock = 1'b0;
    clk_en = 1'b1;
    ev = '0;
    irq_en = 3'h0;
    do_reset();
    rd(0, 0);
    rd(1, 8'h40);
    chk("watchdog_enable", 1, wd_en);
    c = count;
    repeat (30) @(posedge clock);
    #1;
    chk("forced_run", 1, count != c);
    $display("test reset done");
    wr(1, 8'h9F);
    rd(1, md);
    wr(1, 8'h99);
    rd(1, md);
    wr(0, 8'hFF);
    rd(0, ctl);
    wr(0, 0);
    c = count;
    repeat (10) @(posedge clock);
    #1;
    chk("stopped", c, count);
    ev.cpu_idle = 1'b1;
    wr(0, 8'h40);
    c = count;
    repeat (20) @(posedge clock);
    #1;
    chk("idle", c, count);
    ev.cpu_idle = 1'b0;
    clk_en = 1'b0;
    c = count;
    repeat (10) @(posedge clock);
    #1;
    chk("clk_en_freeze", c, count);
    clk_en = 1'b1;
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      wr(1, k << 1);
      for (int i = 0; i < 3; i++) begin
        t = 0;
        do begin
          @(negedge clock);
          t++;
        end while (tick !== 1'b1 && t < 400);
        c = count;
        @(posedge clock);
        #1;
        chk("count_step", c + 16'h0001, count);
      end
      chk("tick_gap", gap[k], t);
    end
    wr(1, 8'h0C);
    c = count;
    repeat (20) @(posedge clock);
    #1;
    chk("reserved_sel", c, count);
    $display("test timebase done");
    wr(1, 8'h08);
    wr(0, 0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      ev.match_event = 3'($random(seed));
      irq_en = 3'($random(seed));
      ctl = ctl | ev.match_event;
      @(posedge clock);
      #1;
      ev.match_event = 3'h0;
      chk("irq", |(ctl[2:0] & irq_en), irq);
      rd(0, ctl);
    end
    wr(1, 8'h09);
    wr(0, 8'h40);
    t = 0;
    while (count !== 16'hFFFF && t < 70000) begin
      @(negedge clock);
      t++;
    end
    @(posedge clock);
    #1;
    ctl = ctl | 8'h80;
    chk("wrap", 0, count);
    chk("irq", 1, irq);
    rd(0, ctl);
    wr(1, 8'h08);
    chk("irq", |(ctl[2:0] & irq_en), irq);
    $display("test flags done");
    wr(1, 8'h20);
    wr(1, 0);
    rd(1, md);
    chk("watchdog_enable", 1, wd_en);
    wr(0, 8'h04);
    chk("watchdog_reset", 1, wd_rst);
    do_reset();
    rd(1, md);
    $display("test watchdog done");
    end_of_test();
  end
endmodule
`default_nettype wire
